// ### inc/rfa_pkg.sv
// Shared constants and types of the receive frame area writer
package rfa_pkg;
  // All-ones pointer marks an absent descriptor
  localparam logic [31:0] ALL_ONES = 32'hFFFF_FFFF;
  // Frame descriptor byte offsets
  localparam logic [31:0] FD_OFS_CMD = 32'h0000_0000;
  localparam logic [31:0] FD_OFS_LINK = 32'h0000_0004;
  localparam logic [31:0] FD_OFS_RBD = 32'h0000_0008;
  localparam logic [31:0] FD_OFS_CNT = 32'h0000_000C;
  localparam logic [31:0] FD_OFS_DATA = 32'h0000_0010;
  // Buffer descriptor byte offsets
  localparam logic [31:0] BD_OFS_CNT = 32'h0000_0000;
  localparam logic [31:0] BD_OFS_LINK = 32'h0000_0004;
  localparam logic [31:0] BD_OFS_BUF = 32'h0000_0008;
  localparam logic [31:0] BD_OFS_SIZE = 32'h0000_000C;
  // Field positions
  localparam int FD_B_EL = 31;
  localparam int FD_B_S = 30;
  localparam int FD_B_SF = 19;
  localparam int ST_C = 15;
  localparam int ST_B = 14;
  localparam int ST_OK = 13;
  localparam int CNT_EOF = 15;
  localparam int CNT_F = 14;
  localparam int SIZE_LSB = 16;
  localparam int BD_EL = 15;
  localparam int CNT_W = 14;
  // Register offsets
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_HEAD = 12'h004;
  localparam logic [11:0] REG_STAT = 12'h008;
  localparam logic [11:0] REG_NORES = 12'h00C;
  // Control register bits and the status register refused bit
  localparam int CTRL_START = 0;
  localparam int CTRL_SAVE_BAD = 1;
  localparam int CTRL_PROMISC = 2;
  localparam int CTRL_RESUME = 3;
  localparam int CTRL_MODE_LSB = 4;
  localparam int STAT_REFUSED = 4;
  typedef enum logic [1:0] {RFA_MODE_COMPAT, RFA_MODE_SEG32, RFA_MODE_LINEAR} rfa_mode_type;
  typedef enum logic [1:0] {RU_IDLE, RU_READY, RU_SUSP, RU_NORES} rfa_ru_type;
  // Memory master request and answer
  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
  } rfa_mreq_type;
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } rfa_mrsp_type;
  // Received byte stream
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
    logic err;
    logic match;
  } rfa_rx_type;
  typedef struct packed {
    logic start;
    logic resume;
    logic save_bad;
    logic promisc;
    rfa_mode_type mode;
    logic [31:0] head;
  } rfa_cfg_type;
  typedef struct packed {
    rfa_ru_type ru;
    logic refused;
    logic [31:0] nores;
  } rfa_stat_type;
endpackage

// ### core/rfa_cnt.sv
// Saturating event counter
module rfa_cnt #(
  parameter int W = 32
) (
  input wire logic clk, // Clock
  input wire logic nrst, // Async reset, active low
  input wire logic inc, // Count pulse
  output logic [31:0] count // Counter value, zero extended
);
  import rfa_pkg::*;
  typedef struct packed {
    logic [W-1:0] c;
  } rfa_cnt_state_type;
  rfa_cnt_state_type r, n;

  // Width must fit the 32-bit read path
  if (W < 1 || W > 32) $error("rfa_cnt: W out of range");

  // Stick at all ones instead of wrapping
  always_comb
  begin
    n = r;
    if (inc && ~&r.c) n.c = r.c + 1'b1;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst) r <= '0;
    else r <= n;
  end

  assign count = 32'(r.c);
endmodule // rfa_cnt

// ### core/rfa_apb.sv
// APB register slave of the receive frame area writer
module rfa_apb (
  input wire logic clk, // Clock
  input wire logic nrst, // Async reset, active low
  input wire logic [11:0] paddr, // APB address
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [31:0] pwdata, // APB write data
  input rfa_pkg::rfa_stat_type stat, // Block status
  output rfa_pkg::rfa_cfg_type cfg, // Control to the writer
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr // APB error
);
  import rfa_pkg::*;
  typedef struct packed {
    rfa_cfg_type cfg;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rfa_apb_state_type;
  rfa_apb_state_type r, n;

  // Read data prepared in setup, writes land at the access edge
  always_comb
  begin
    n = r;
    n.cfg.start = 1'b0;
    n.cfg.resume = 1'b0;
    n.pready = psel && !penable;
    if (psel && !penable)
    begin
      n.prdata = '0;
      n.pslverr = 1'b0;
      if (paddr == REG_CTRL)
        n.prdata = {26'h0, r.cfg.mode, 1'b0, r.cfg.promisc, r.cfg.save_bad, 1'b0};
      else if (paddr == REG_HEAD)
        n.prdata = r.cfg.head;
      else if (paddr == REG_STAT)
        n.prdata = {27'h0, stat.refused, 2'b0, stat.ru};
      else if (paddr == REG_NORES)
        n.prdata = stat.nores;
      else
        n.pslverr = 1'b1;
    end
    if (psel && penable && r.pready && pwrite && !r.pslverr)
    begin
      if (paddr == REG_CTRL)
      begin
        n.cfg.start = pwdata[CTRL_START];
        n.cfg.resume = pwdata[CTRL_RESUME];
        n.cfg.save_bad = pwdata[CTRL_SAVE_BAD];
        n.cfg.promisc = pwdata[CTRL_PROMISC];
        n.cfg.mode = rfa_mode_type'(pwdata[CTRL_MODE_LSB +: 2]);
      end
      else if (paddr == REG_HEAD)
        n.cfg.head = pwdata;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst) r <= '0;
    else r <= n;
  end

  assign cfg = r.cfg;
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
endmodule // rfa_apb

// ### core/rfa_writer.sv
// Receive frame area writer: stores frames into descriptor chains in memory
module rfa_writer #(
  parameter int NORES_CNT_W = 32
) (
  input wire logic clk, // Clock, 125 MHz
  input wire logic nrst, // Async reset, active low
  input wire logic [11:0] paddr, // APB address
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  output rfa_pkg::rfa_mreq_type mem_req, // Memory request
  input rfa_pkg::rfa_mrsp_type mem_rsp, // Memory answer
  input rfa_pkg::rfa_rx_type rx, // Received bytes
  output logic rx_ready // Byte taken when high with valid
);
  import rfa_pkg::*;
  typedef enum logic [3:0] {
    IDLE, FD_HDR, FD_MARK, RB_FETCH, RX_WAIT, RX_PUT, RB_CLOSE,
    FR_END, FR_CNT, FR_DONE, FR_LINK, SUSP, NORES
  } rfa_st_type;
  typedef struct packed {
    rfa_st_type st;
    logic [1:0] idx;
    logic first;
    logic [31:0] fd_ptr;
    logic [31:0] fd_link;
    logic el;
    logic s;
    logic sf;
    logic [CNT_W-1:0] fd_size;
    logic [CNT_W-1:0] cnt;
    logic [31:0] rbd_ptr;
    logic [31:0] rbd_first;
    logic [31:0] rbd_link;
    logic [31:0] rbd_buf;
    logic [CNT_W-1:0] rbd_size;
    logic rbd_el;
    logic rbd_ok;
    logic [CNT_W-1:0] bcnt;
    logic used;
    logic eof;
    logic hold;
    logic [7:0] byte_r;
    logic last;
    logic err;
    logic nomatch;
    logic trunc;
    logic nores_pend;
    logic cnt_inc;
    logic refused;
    logic rx_ready;
    rfa_mreq_type mreq;
  } rfa_wr_state_type;
  rfa_wr_state_type r, n;
  rfa_cfg_type cfg;
  rfa_stat_type stat;
  logic [31:0] nores_cnt;
  logic done;
  logic bad;

  if (NORES_CNT_W < 1 || NORES_CNT_W > 32) $error("rfa_writer: NORES_CNT_W out of range");

  // Register slave
  rfa_apb u_apb (
    .clk(clk),
    .nrst(nrst),
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pwdata(pwdata),
    .stat(stat),
    .cfg(cfg),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr)
  );

  // No-resource error counter
  rfa_cnt #(.W(NORES_CNT_W)) u_nores (
    .clk(clk),
    .nrst(nrst),
    .inc(r.cnt_inc),
    .count(nores_cnt)
  );

  // Memory request builders
  function automatic rfa_mreq_type mrd(input logic [31:0] a);
    rfa_mreq_type m;
    m = '0;
    m.req = 1'b1;
    m.addr = a;
    m.be = 4'hF;
    return m;
  endfunction

  function automatic rfa_mreq_type mwr(input logic [31:0] a, input logic [31:0] d,
                                       input logic [3:0] be);
    rfa_mreq_type m;
    m.req = 1'b1;
    m.we = 1'b1;
    m.addr = a;
    m.wdata = d;
    m.be = be;
    return m;
  endfunction

  // Byte store: little endian lane picked by low address bits
  function automatic rfa_mreq_type mbyte(input logic [31:0] a, input logic [7:0] b);
    return mwr({a[31:2], 2'b00}, {4{b}}, 4'(4'h1 << a[1:0]));
  endfunction

  // Status view for software
  always_comb
  begin
    stat.refused = r.refused;
    stat.nores = nores_cnt;
    case (r.st)
      IDLE: stat.ru = RU_IDLE;
      SUSP: stat.ru = RU_SUSP;
      NORES: stat.ru = RU_NORES;
      default: stat.ru = RU_READY;
    endcase
  end

  assign done = r.mreq.req && mem_rsp.ack;
  assign bad = r.err || r.trunc;

  // Main sequencer; one memory access at a time, each waits for ack
  always_comb
  begin
    n = r;
    n.cnt_inc = 1'b0;
    if (done) n.mreq.req = 1'b0;
    case (r.st)
      IDLE, SUSP, NORES:
      begin
        if (cfg.start)
        begin
          if (cfg.mode == RFA_MODE_COMPAT) n.refused = 1'b1;
          else
          begin
            n.refused = 1'b0;
            n.fd_ptr = cfg.head;
            n.first = 1'b1;
            n.idx = '0;
            n.st = FD_HDR;
          end
        end
        else if (cfg.resume && r.st == SUSP)
        begin
          n.idx = '0;
          n.st = r.sf ? FR_LINK : FD_HDR;
        end
      end
      // Read command, link, buffer pointer and size words
      FD_HDR:
      begin
        if (!r.mreq.req) n.mreq = mrd(r.fd_ptr + {28'h0, r.idx, 2'b00});
        if (done)
        begin
          case (r.idx)
            2'd0:
            begin
              n.el = mem_rsp.rdata[FD_B_EL];
              n.s = mem_rsp.rdata[FD_B_S];
              n.sf = mem_rsp.rdata[FD_B_SF];
            end
            2'd1: n.fd_link = mem_rsp.rdata;
            2'd2: if (r.first) n.rbd_ptr = mem_rsp.rdata;
            default: n.fd_size = mem_rsp.rdata[SIZE_LSB +: CNT_W];
          endcase
          n.idx = r.idx + 2'd1;
          if (r.idx == 2'd3) n.st = FD_MARK;
        end
      end
      // Busy written alone, command half untouched
      FD_MARK:
      begin
        if (!r.mreq.req) n.mreq = mwr(r.fd_ptr + FD_OFS_CMD, 32'(1 << ST_B), 4'h3);
        if (done)
        begin
          n.first = 1'b0;
          n.cnt = '0;
          n.bcnt = '0;
          n.used = 1'b0;
          n.trunc = 1'b0;
          n.err = 1'b0;
          n.nomatch = 1'b0;
          n.rbd_first = r.rbd_ptr;
          n.rbd_ok = 1'b0;
          n.idx = 2'd1;
          if (r.sf && r.rbd_ptr != ALL_ONES) n.st = RB_FETCH;
          else
          begin
            n.st = RX_WAIT;
            n.rx_ready = 1'b1;
          end
        end
      end
      // First buffer descriptor of a frame fetched ahead of its first byte, later ones while the held byte waits
      RB_FETCH:
      begin
        if (!r.mreq.req) n.mreq = mrd(r.rbd_ptr + {28'h0, r.idx, 2'b00});
        if (done)
        begin
          case (r.idx)
            2'd1: n.rbd_link = mem_rsp.rdata;
            2'd2: n.rbd_buf = mem_rsp.rdata;
            default:
            begin
              n.rbd_size = mem_rsp.rdata[CNT_W-1:0];
              n.rbd_el = mem_rsp.rdata[BD_EL];
            end
          endcase
          n.idx = r.idx + 2'd1;
          if (r.idx == 2'd3)
          begin
            n.rbd_ok = 1'b1;
            n.bcnt = '0;
            n.st = r.hold ? RX_PUT : RX_WAIT;
            n.rx_ready = !r.hold;
          end
        end
      end
      RX_WAIT:
      begin
        if (rx.valid && r.rx_ready)
        begin
          n.rx_ready = 1'b0;
          n.hold = 1'b1;
          n.byte_r = rx.data;
          n.last = rx.last;
          n.err = r.err || rx.err;
          n.nomatch = r.nomatch || (!rx.match && !cfg.promisc);
          n.st = RX_PUT;
        end
      end
      // Descriptor area first, then buffers, else drop
      RX_PUT:
      begin
        if (r.cnt < r.fd_size)
        begin
          if (!r.mreq.req) n.mreq = mbyte(r.fd_ptr + FD_OFS_DATA + 32'(r.cnt), r.byte_r);
          if (done) n.cnt = r.cnt + 1'b1;
        end
        else if (r.sf && r.rbd_ok && r.bcnt < r.rbd_size)
        begin
          if (!r.mreq.req) n.mreq = mbyte(r.rbd_buf + 32'(r.bcnt), r.byte_r);
          if (done) n.bcnt = r.bcnt + 1'b1;
        end
        else if (r.sf && r.rbd_ok)
        begin
          // A cut frame ends in the buffer that ran out
          n.eof = r.rbd_el || r.rbd_link == ALL_ONES;
          n.st = RB_CLOSE;
        end
        else
          n.trunc = 1'b1;
        if (done || (!(r.cnt < r.fd_size) && !(r.sf && r.rbd_ok)))
        begin
          n.hold = 1'b0;
          n.st = r.last ? FR_END : RX_WAIT;
          n.rx_ready = !r.last;
        end
      end
      // Buffer count word; end-of-frame only on the last one
      RB_CLOSE:
      begin
        if (!r.mreq.req)
          n.mreq = mwr(r.rbd_ptr + BD_OFS_CNT,
                       {16'h0, r.eof, 1'b1, r.bcnt}, 4'h3);
        if (done)
        begin
          n.used = 1'b1;
          if (r.rbd_el || r.rbd_link == ALL_ONES)
          begin
            n.rbd_ok = 1'b0;
            n.nores_pend = 1'b1;
          end
          else
            n.rbd_ptr = r.rbd_link;
          n.idx = 2'd1;
          if (!r.hold) n.st = FR_CNT;
          else if (r.rbd_el || r.rbd_link == ALL_ONES) n.st = RX_PUT;
          else n.st = RB_FETCH;
        end
      end
      FR_END:
      begin
        n.cnt_inc = r.trunc;
        if (r.nomatch || (bad && !cfg.save_bad))
        begin
          n.rbd_ptr = r.rbd_first;
          n.cnt = '0;
          n.bcnt = '0;
          n.used = 1'b0;
          n.trunc = 1'b0;
          n.err = 1'b0;
          n.nomatch = 1'b0;
          n.nores_pend = 1'b0;
          n.idx = 2'd1;
          n.rbd_ok = 1'b0;
          if (r.sf && r.rbd_first != ALL_ONES) n.st = RB_FETCH;
          else
          begin
            n.st = RX_WAIT;
            n.rx_ready = 1'b1;
          end
        end
        else if (r.sf && r.rbd_ok && (r.used || r.bcnt != '0))
        begin
          n.eof = 1'b1;
          n.st = RB_CLOSE;
        end
        else
          n.st = FR_CNT;
      end
      FR_CNT:
      begin
        if (!r.mreq.req)
          n.mreq = mwr(r.fd_ptr + FD_OFS_CNT, {16'h0, 1'b1, 1'b1, r.cnt}, 4'h3);
        if (done) n.st = FR_DONE;
      end
      // Complete and busy change in one write
      FR_DONE:
      begin
        if (!r.mreq.req)
          n.mreq = mwr(r.fd_ptr + FD_OFS_CMD,
                       32'((1 << ST_C) | (32'(!bad) << ST_OK)), 4'h3);
        if (done)
        begin
          n.idx = '0;
          if (r.nores_pend || r.el) n.st = NORES;
          else
          begin
            // Pointer moves on before a suspend, so resume starts afresh
            n.fd_ptr = r.fd_link;
            if (r.s) n.st = SUSP;
            else n.st = r.sf ? FR_LINK : FD_HDR;
          end
          n.nores_pend = 1'b0;
        end
      end
      FR_LINK:
      begin
        if (!r.mreq.req) n.mreq = mwr(r.fd_ptr + FD_OFS_RBD, r.rbd_ptr, 4'hF);
        if (done) n.st = FD_HDR;
      end
      default: n.st = IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst) r <= '0;
    else r <= n;
  end

  assign mem_req = r.mreq;
  assign rx_ready = r.rx_ready;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  busy_mark_a: assert property ((r.st == FD_MARK && r.mreq.req) |->
    r.mreq.wdata[ST_B] && !r.mreq.wdata[ST_C]) else $error("busy mark wrong");
  done_word_a: assert property ((r.st == FR_DONE && r.mreq.req) |->
    r.mreq.wdata[ST_C] && !r.mreq.wdata[ST_B]) else $error("complete word wrong");
  buf_bound_a: assert property (r.rbd_ok |-> r.bcnt <= r.rbd_size)
    else $error("buffer overfilled");
  simple_trunc_a: assert property ((r.st == RX_PUT && !r.sf && r.cnt == r.fd_size)
    |=> r.trunc) else $error("no truncation");
  trunc_count_a: assert property ((r.st == FR_END && r.trunc) |=> r.cnt_inc)
    else $error("truncation not counted");
  bad_reuse_a: assert property ((r.st == FR_END && r.trunc && !cfg.save_bad)
    |=> r.fd_ptr == $past(r.fd_ptr) && r.cnt == '0) else $error("descriptor not reused");
  nores_enter_a: assert property ((r.st == FR_DONE && done && r.nores_pend)
    |=> r.st == NORES) else $error("no resources missed");
  susp_enter_a: assert property ((r.st == FR_DONE && done && r.s && !r.el
    && !r.nores_pend) |=> r.st == SUSP) else $error("suspend missed");
  next_link_a: assert property ((r.st == FR_LINK && r.mreq.req) |->
    r.mreq.wdata == r.rbd_ptr) else $error("next buffer pointer wrong");
  mode_refuse_a: assert property ((r.st == IDLE && cfg.start && cfg.mode == RFA_MODE_COMPAT)
    |=> r.st == IDLE && r.refused) else $error("start not refused");
endmodule // rfa_writer

// ### test/rfa_mem_model.sv
// Host memory model that answers the block's memory requests
module rfa_mem_model
  import rfa_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic nrst, // Reset, active low
  input rfa_pkg::rfa_mreq_type req, // Request from the block
  input wire logic [3:0] dly, // Wait cycles before each answer
  output rfa_pkg::rfa_mrsp_type rsp // Answer to the block
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [0:1023];
  logic [3:0] cnt;

  // Marker fill, so any stray or excess write shows up
  initial
  begin
    for (int i = 0; i < 1024; i++)
      mem[i] = 32'hCCCC_CCCC;
  end

  // One access at a time, answered after dly idle cycles
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt <= '0;
      rsp <= '0;
    end
    else if (rsp.ack || !req.req)
    begin
      cnt <= '0;
      rsp.ack <= 1'b0;
      rsp.rdata <= ~rsp.rdata; // Stale data never looks valid
    end
    else if (cnt == dly)
    begin
      rsp.ack <= 1'b1;
      rsp.rdata <= mem[req.addr[11:2]];
      for (int b = 0; b < 4; b++)
      begin
        if (req.we && req.be[b])
          mem[req.addr[11:2]][8*b +: 8] <= req.wdata[8*b +: 8];
      end
    end
    else
      cnt <= cnt + 4'h1;
  end
endmodule // rfa_mem_model

// ### test/rfa_writer_tb.sv
// Self-checking bench of the receive frame area writer
module rfa_writer_tb;
  import rfa_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [11:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  rfa_mreq_type mem_req;
  rfa_mrsp_type mem_rsp;
  rfa_rx_type rx = '0;
  logic rx_ready;
  logic [3:0] dly = 4'h0;
  int fail_count = 0;
  int n_compared = 0;
  localparam logic [31:0] LIN = 32'h0000_0020; // Linear mode field

  // 125 MHz clock
  always #4 clk = ~clk;

  rfa_writer rfa_writer_i (.clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req(mem_req), .mem_rsp(mem_rsp), .rx(rx), .rx_ready(rx_ready));
  rfa_mem_model rfa_mem_model_i (.clk(clk), .nrst(nrst), .req(mem_req), .dly(dly),
    .rsp(mem_rsp));

  // Verdict and end of run, also reached when a wait runs out
  task automatic results();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic timeout(input string n);
    fail_count++;
    $display("CHECK FAILED %s expected answer seen timeout", n);
    results();
  endtask

  // APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    int t;
    t = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      t++;
    end
    while (!pready && t < 50);
    if (t >= 50)
      timeout("pready");
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input string n, input logic [11:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, '0, q, e);
    chk(n, x, q);
  endtask

  // Host side view of shared memory
  task automatic setw(input logic [31:0] a, input logic [31:0] d);
    rfa_mem_model_i.mem[a[11:2]] = d;
  endtask

  function automatic logic [31:0] getw(input logic [31:0] a);
    return rfa_mem_model_i.mem[a[11:2]];
  endfunction

  function automatic logic [31:0] getb(input logic [31:0] a);
    return {24'h00_0000, rfa_mem_model_i.mem[a[11:2]][8*a[1:0] +: 8]};
  endfunction

  task automatic set_fd(input logic [31:0] a, input logic [31:0] w0, input logic [31:0] lk,
    input logic [31:0] bd, input logic [15:0] sz);
    setw(a, w0);
    setw(a + FD_OFS_LINK, lk);
    setw(a + FD_OFS_RBD, bd);
    setw(a + FD_OFS_CNT, {sz, 16'h0000});
  endtask

  // Buffers sit on even addresses and stay far below the size ceiling
  task automatic set_bd(input logic [31:0] a, input logic [31:0] lk, input logic [31:0] b,
    input logic [15:0] sz);
    setw(a, 32'h0000_0000);
    setw(a + BD_OFS_LINK, lk);
    setw(a + BD_OFS_BUF, b);
    setw(a + BD_OFS_SIZE, {16'h0000, sz});
  endtask

  // One frame of counting bytes; data is scrambled once released
  task automatic send(input int n, input logic [7:0] b0, input logic m);
    int t;
    for (int k = 0; k < n; k++)
    begin
      rx <= '{valid: 1'b1, data: b0 + 8'(k), last: k == n - 1, err: 1'b0, match: m};
      t = 0;
      do
      begin
        @(posedge clk);
        t++;
      end
      while (!rx_ready && t < 2000);
      if (t >= 2000)
        timeout("rx_ready");
    end
    rx <= '{valid: 1'b0, data: ~(b0 + 8'(n - 1)), last: 1'b0, err: 1'b0, match: 1'b0};
    @(posedge clk);
  endtask

  task automatic wait_c(input logic [31:0] a);
    int t;
    t = 0;
    while ((getw(a) & 32'h0000_8000) == 32'h0 && t < 3000)
    begin
      @(posedge clk);
      t++;
    end
    if (t >= 3000)
      timeout("complete bit");
  endtask

  // State may settle a little after completion, so poll a bounded while
  task automatic poll_st(input logic [1:0] x);
    logic [31:0] q;
    logic e;
    int t;
    t = 0;
    do
    begin
      apb(1'b0, REG_STAT, '0, q, e);
      t++;
    end
    while (q[1:0] !== x && t < 100);
    chk("unit state", {30'h0, x}, {30'h0, q[1:0]});
  endtask

  task automatic t_regs();
    logic [31:0] q;
    logic e;
    rd("ctrl reset", REG_CTRL, '0);
    rd("stat reset", REG_STAT, '0);
    rd("nores reset", REG_NORES, '0);
    apb(1'b0, 12'h010, '0, q, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", '0, q);
    wr(REG_STAT, 32'h0000_0003);
    rd("stat read only", REG_STAT, '0);
    wr(REG_CTRL, 32'h0000_0001);
    rd("compat start", REG_STAT, 32'h0000_0010);
  endtask

  task automatic t_simple();
    set_fd(32'h100, 32'h0, 32'h200, ALL_ONES, 16'h0008);
    set_fd(32'h200, 32'h4000_0000, 32'h300, ALL_ONES, 16'h0008);
    wr(REG_HEAD, 32'h0000_0100);
    wr(REG_CTRL, LIN | 32'h1);
    send(12, 8'h10, 1'b1);
    send(5, 8'h40, 1'b1);
    wait_c(32'h100);
    rd("nores one", REG_NORES, 32'h1);
    chk("fd status", 32'hA000, getw(32'h100) & 32'hFFFF);
    chk("fd count", 32'h0008_C005, getw(32'h10C));
    for (int k = 0; k < 5; k++)
      chk("fd byte", 32'h40 + 32'(k), getb(32'h110 + 32'(k)));
    chk("fd end", 32'hCC, getb(32'h118));
    wr(REG_CTRL, LIN | 32'h6);
    send(10, 8'h80, 1'b0);
    wait_c(32'h200);
    poll_st(2'd2);
    rd("nores two", REG_NORES, 32'h2);
    chk("bad status", 32'h8000, getw(32'h200) & 32'hFFFF);
    chk("bad count", 32'h0008_C008, getw(32'h20C));
    for (int k = 0; k < 8; k++)
      chk("bad byte", 32'h80 + 32'(k), getb(32'h210 + 32'(k)));
    chk("bad end", 32'hCC, getb(32'h218));
    set_fd(32'h300, 32'h8000_0000, 32'h600, ALL_ONES, 16'h0008);
    wr(REG_CTRL, LIN | 32'hE);
    send(3, 8'hA0, 1'b1);
    wait_c(32'h300);
    poll_st(2'd3);
    chk("resume status", 32'hA000, getw(32'h300) & 32'hFFFF);
    chk("resume byte", 32'hA0, getb(32'h310));
  endtask

  task automatic t_flex();
    logic [31:0] a;
    dly <= 4'h3;
    set_fd(32'h300, 32'h0008_0000, 32'h600, 32'h400, 16'h0004);
    set_bd(32'h400, 32'h410, 32'h500, 16'h0004);
    set_bd(32'h410, 32'h420, 32'h520, 16'h0006);
    set_bd(32'h420, ALL_ONES, 32'h540, 16'h8008);
    set_fd(32'h600, 32'h8008_0000, ALL_ONES, ALL_ONES, 16'h0004);
    wr(REG_HEAD, 32'h0000_0300);
    wr(REG_CTRL, LIN | 32'h3);
    send(11, 8'h20, 1'b1);
    wait_c(32'h300);
    chk("flex status", 32'hA000, getw(32'h300) & 32'hFFFF);
    chk("first buf", 32'h4004, getw(32'h400) & 32'hFFFF);
    chk("last buf", 32'hC003, getw(32'h410) & 32'hFFFF);
    chk("fd to buf", 32'h400, getw(32'h308));
    for (int k = 0; k < 11; k++)
    begin
      a = (k < 4) ? 32'h310 + 32'(k) : (k < 8) ? 32'h4FC + 32'(k) : 32'h518 + 32'(k);
      chk("flex byte", 32'h20 + 32'(k), getb(a));
    end
    chk("buf limit", 32'hCC, getb(32'h504));
    send(14, 8'h60, 1'b1);
    wait_c(32'h600);
    poll_st(2'd3);
    chk("next free", 32'h420, getw(32'h608));
    chk("exhaust buf", 32'hC008, getw(32'h420) & 32'hFFFF);
    for (int k = 0; k < 8; k++)
      chk("spill byte", 32'h64 + 32'(k), getb(32'h540 + 32'(k)));
    chk("spill limit", 32'hCC, getb(32'h548));
    rd("nores three", REG_NORES, 32'h3);
  endtask

  // Reset for 8 cycles, then the scenarios in turn
  initial
  begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_regs();
    t_simple();
    t_flex();
    results();
  end
endmodule // rfa_writer_tb
